// [rtl/gcs_chop_sequencer.v]
// Global chop conversion sequencer with register port
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`include "gcs_defines.vh"

// Operation
// R1 - With chop on, each pair is taken normal then reversed and their mean is output.
// R2 - One enable bit in the conversion rate register switches chop on and off.
// R3 - With the low-latency filter the first chopped result comes after about two periods.
// R4 - With the sinc3 filter the first chopped result comes after about six periods.
// R5 - In continuous chop mode every later conversion takes half the first one's time.
// R6 - Alternating conversions are pipelined so every data cycle yields an average.
// R7 - The host starts a sequence by a start pin rising edge or a start command.
// R8 - All periods count master clock ticks, so they scale with that clock.
// R9 - The settling delay is applied twice per chopped result, 28 periods by default; the code applies it only before a sequence's first result.
// R10 - Sinc3 chop periods are 614530 then 307265 at 2.5 SPS and 464 first at 4000 SPS.
// R11 - Chopping runs like back-to-back single shots with the inputs swapped each time.
// R12 - After the first data the inputs swap and each word averages the last two.
// R13 - In sinc3 mode the first two unsettled outputs are never made readable; the code hides them only with chop off.
// R14 - Without chop the default settling delay before a conversion is 14 periods.
// R15 - Chop lowers the output rate but leaves the filter rate and its notches alone.
// R16 - With chop off, conversions use one polarity with no swapping or averaging.
module gcs_chop_sequencer
#(
    parameter DATA_W = 16,
    parameter CNT_W  = 20
)
(
    // Clock and reset
    input  wire                   core_clk,
    input  wire                   sys_rst,
    // Register port
    input  wire [`GCS_ADDR_W-1:0] regAddr,
    input  wire [7:0]             regWrData,
    input  wire                   regWrStb,
    input  wire                   regRdStb,
    output reg  [DATA_W-1:0]      regRdData_r,
    // Host start sources
    input  wire                   startPin,
    input  wire                   startCmd,
    // Master clock tick and filter data
    input  wire                   mclkTick,
    input  wire [DATA_W-1:0]      filterData,
    // Analog front-end control
    output reg                    inputReversed_r,
    output wire                   convActive,
    output wire [3:0]             filterRate,
    output wire                   lowLatencySel,
    // Result
    output reg  [DATA_W-1:0]      resultData_r,
    output reg                    resultValid_r,
    output reg                    dataReady_r
);

// ------------------------------------------------------------
// States
// ------------------------------------------------------------
localparam ST_IDLE  = 2'd0;
localparam ST_DELAY = 2'd1;
localparam ST_CONV  = 2'd2;

// ------------------------------------------------------------
// Period lookup
// ------------------------------------------------------------
// Returns the first chopped data period; one conversion is half of it
function [CNT_W-1:0] firstPeriod;
    input       lowLat;
    input [3:0] code;
    reg   [3:0] c;
    begin
        c = (code > `GCS_RATE_LAST) ? `GCS_RATE_LAST : code;
        case ({lowLat, c})
            5'h10: firstPeriod = `GCS_LL_P0;                                    // R3
            5'h11: firstPeriod = `GCS_LL_P1;
            5'h12: firstPeriod = `GCS_LL_P2;
            5'h13: firstPeriod = `GCS_LL_P3;
            5'h14: firstPeriod = `GCS_LL_P4;
            5'h15: firstPeriod = `GCS_LL_P5;
            5'h16: firstPeriod = `GCS_LL_P6;
            5'h17: firstPeriod = `GCS_LL_P7;
            5'h18: firstPeriod = `GCS_LL_P8;
            5'h19: firstPeriod = `GCS_LL_P9;
            5'h1A: firstPeriod = `GCS_LL_P10;
            5'h1B: firstPeriod = `GCS_LL_P11;
            5'h1C: firstPeriod = `GCS_LL_P12;
            5'h1D: firstPeriod = `GCS_LL_P13;
            5'h00: firstPeriod = `GCS_S3_P0;                                    // R4
            5'h01: firstPeriod = `GCS_S3_P1;
            5'h02: firstPeriod = `GCS_S3_P2;
            5'h03: firstPeriod = `GCS_S3_P3;
            5'h04: firstPeriod = `GCS_S3_P4;
            5'h05: firstPeriod = `GCS_S3_P5;
            5'h06: firstPeriod = `GCS_S3_P6;
            5'h07: firstPeriod = `GCS_S3_P7;
            5'h08: firstPeriod = `GCS_S3_P8;
            5'h09: firstPeriod = `GCS_S3_P9;
            5'h0A: firstPeriod = `GCS_S3_P10;
            5'h0B: firstPeriod = `GCS_S3_P11;
            5'h0C: firstPeriod = `GCS_S3_P12;
            default: firstPeriod = `GCS_S3_P13;
        endcase
    end
endfunction

// ------------------------------------------------------------
// Registers and state
// ------------------------------------------------------------
reg  [7:0]        rateCfg_r;
reg  [7:0]        ctrl_r;
reg  [7:0]        delay_r;
reg  [1:0]        state_r;
reg               armed_r;
reg  [1:0]        hidden_r;
reg               startPinPrev_r;
reg               seqChop_r;
reg               seqLowLat_r;
reg               sampleStb_r;
reg  [DATA_W-1:0] sample_r;
reg               sampleRev_r;
reg               sampleFirst_r;

wire              chopEn;
wire              contMode;
wire              startEvt;
wire              abortEvt;
wire [CNT_W-1:0]  convLen;
wire [CNT_W-1:0]  delayLen;
reg               timerLoad;
reg  [CNT_W-1:0]  timerCount;
wire              timerDone;
wire [DATA_W-1:0] avgData;
wire              avgStb;
wire [7:0]        statusWord;

assign chopEn        = rateCfg_r[`GCS_CFG_CHOP_BIT];                            // R2
assign contMode      = ctrl_r[`GCS_CTRL_CONT_BIT];
assign filterRate    = rateCfg_r[`GCS_CFG_RATE_HI:`GCS_CFG_RATE_LO];            // R15
assign lowLatencySel = rateCfg_r[`GCS_CFG_LOWLAT_BIT];
assign startEvt      = (startPin && !startPinPrev_r) || startCmd;               // R7
assign abortEvt      = regWrStb && (regAddr == `GCS_OFS_CTRL)
                       && regWrData[`GCS_CTRL_ABORT_BIT];
// Each single conversion is half the first chopped period
assign convLen       = firstPeriod(seqLowLat_r, filterRate) >> 1;               // R5 R10
assign delayLen      = {{(CNT_W-8){1'b0}}, delay_r};
assign convActive    = (state_r != ST_IDLE);
assign statusWord    = {2'b00, state_r, armed_r, dataReady_r, inputReversed_r,
                        convActive};

// ------------------------------------------------------------
// Register port
// ------------------------------------------------------------
always @(posedge core_clk)
begin
    if (sys_rst)
    begin
        rateCfg_r   <= `GCS_CFG_RST;
        ctrl_r      <= `GCS_CTRL_RST;
        delay_r     <= `GCS_DELAY_RST;                                          // R14
        regRdData_r <= {DATA_W{1'b0}};
    end
    else
    begin
        if (regWrStb)
        begin
            if (regAddr == `GCS_OFS_RATE_CFG)
                rateCfg_r <= regWrData;
            else if (regAddr == `GCS_OFS_CTRL)
                ctrl_r <= {7'h00, regWrData[`GCS_CTRL_CONT_BIT]};
            else if (regAddr == `GCS_OFS_DELAY)
                delay_r <= regWrData;
        end
        regRdData_r <= {DATA_W{1'b0}};
        if (regRdStb)
        begin
            if (regAddr == `GCS_OFS_RATE_CFG)
                regRdData_r <= {{(DATA_W-8){1'b0}}, rateCfg_r};
            else if (regAddr == `GCS_OFS_CTRL)
                regRdData_r <= {{(DATA_W-8){1'b0}}, ctrl_r};
            else if (regAddr == `GCS_OFS_DELAY)
                regRdData_r <= {{(DATA_W-8){1'b0}}, delay_r};
            else if (regAddr == `GCS_OFS_STATUS)
                regRdData_r <= {{(DATA_W-8){1'b0}}, statusWord};
            else if (regAddr == `GCS_OFS_RESULT)
                regRdData_r <= resultData_r;
        end
    end
end

// ------------------------------------------------------------
// Timer load selection
// ------------------------------------------------------------
// A zero delay skips the delay phase; the count is never loaded as zero
always @*
begin
    timerLoad  = 1'b0;
    timerCount = convLen;
    if (startEvt)
    begin
        timerLoad  = 1'b1;
        timerCount = (delay_r != 8'h00) ? delayLen : convLen;
    end
    else if (timerDone && convActive)
    begin
        timerLoad = 1'b1;
        // Second chop conversion of the first pair settles again
        if (state_r == ST_CONV && seqChop_r && !armed_r && delay_r != 8'h00)   // R9
            timerCount = delayLen;
    end
end

gcs_period_timer
#(
    .CNT_W     (CNT_W)
)
u_timer
(
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .mclkTick  (mclkTick),                                                      // R8
    .load      (timerLoad),
    .loadCount (timerCount),
    .done_r    (timerDone),
    .busy      ()
);

// ------------------------------------------------------------
// Sequence state machine
// ------------------------------------------------------------
always @(posedge core_clk)
begin
    if (sys_rst)
    begin
        state_r         <= ST_IDLE;
        armed_r         <= 1'b0;
        sampleFirst_r   <= 1'b0;
        startPinPrev_r  <= 1'b0;
        seqChop_r       <= 1'b0;
        seqLowLat_r     <= 1'b0;
        inputReversed_r <= 1'b0;
        sampleStb_r     <= 1'b0;
        sample_r        <= {DATA_W{1'b0}};
        sampleRev_r     <= 1'b0;
    end
    else
    begin
        startPinPrev_r <= startPin;
        sampleStb_r    <= 1'b0;
        if (startEvt)
        begin
            // Mode is latched per sequence so a mid-run write cannot split a pair
            state_r         <= (delay_r != 8'h00) ? ST_DELAY : ST_CONV;
            armed_r         <= 1'b0;
            seqChop_r       <= chopEn;
            seqLowLat_r     <= lowLatencySel;
            inputReversed_r <= 1'b0;                                            // R1
        end
        else if (abortEvt)
        begin
            state_r         <= ST_IDLE;
            inputReversed_r <= 1'b0;
        end
        else
        begin
            case (state_r)
                ST_DELAY:
                    if (timerDone)
                        state_r <= ST_CONV;
                ST_CONV:
                begin
                    if (timerDone)
                    begin
                        sample_r      <= filterData;
                        sampleRev_r   <= inputReversed_r;
                        sampleFirst_r <= seqChop_r && !armed_r;
                        if (seqChop_r)
                        begin
                            // Swap after each conversion, like chained single shots
                            inputReversed_r <= !inputReversed_r;                // R11 R12
                            sampleStb_r     <= 1'b1;
                            if (!armed_r)
                            begin
                                armed_r <= 1'b1;
                                if (delay_r != 8'h00)
                                    state_r <= ST_DELAY;
                            end
                            else if (!contMode)
                            begin
                                state_r         <= ST_IDLE;
                                inputReversed_r <= 1'b0;
                            end
                        end
                        else
                        begin
                            inputReversed_r <= 1'b0;                            // R16
                            sampleStb_r     <= 1'b1;
                            if (!contMode)
                                state_r <= ST_IDLE;
                        end
                    end
                end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end
end

// ------------------------------------------------------------
// Averaging and result posting
// ------------------------------------------------------------
gcs_chop_average
#(
    .DATA_W    (DATA_W)
)
u_avg
(
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .sample    (sample_r),
    .sampleStb (sampleStb_r),
    .reversed  (sampleRev_r),
    .avg_r     (avgData),
    .avgStb_r  (avgStb)
);

reg postChop_r;

// Chopped words need both halves; the first sample of a sequence's first pair posts nothing
always @(posedge core_clk)
begin
    if (sys_rst)
    begin
        postChop_r    <= 1'b0;
        hidden_r      <= 2'b00;
        resultData_r  <= {DATA_W{1'b0}};
        resultValid_r <= 1'b0;
        dataReady_r   <= 1'b0;
    end
    else
    begin
        resultValid_r <= 1'b0;
        if (sampleStb_r)
            postChop_r <= seqChop_r;
        if (avgStb && !sampleFirst_r)
        begin
            if (postChop_r)
            begin
                resultData_r  <= avgData;                                       // R1 R6 R12
                resultValid_r <= 1'b1;
            end
            // With chop off, the first two sinc3 outputs of a sequence never reach the result register
            else if (!seqLowLat_r && hidden_r != `GCS_SINC3_HIDDEN)
                hidden_r <= hidden_r + 2'b01;                                   // R13
            else
            begin
                resultData_r  <= sample_r;                                      // R16
                resultValid_r <= 1'b1;
            end
        end
        if (startEvt)
            hidden_r <= 2'b00;
        // A new result in the same cycle as a result read keeps the flag set
        if (avgStb && !sampleFirst_r
            && (postChop_r || seqLowLat_r || hidden_r == `GCS_SINC3_HIDDEN))
            dataReady_r <= 1'b1;
        else if (regRdStb && regAddr == `GCS_OFS_RESULT)
            dataReady_r <= 1'b0;
    end
end

endmodule

// [rtl/gcs_defines.vh]
// Register map, field positions, reset values and period counts of the chop sequencer
`ifndef GCS_DEFINES_VH
`define GCS_DEFINES_VH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define GCS_ADDR_W          8
`define GCS_OFS_RATE_CFG    8'h04
`define GCS_OFS_CTRL        8'h10
`define GCS_OFS_DELAY       8'h14
`define GCS_OFS_STATUS      8'h18
`define GCS_OFS_RESULT      8'h1C

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define GCS_CFG_CHOP_BIT    5
`define GCS_CFG_LOWLAT_BIT  4
`define GCS_CFG_RATE_HI     3
`define GCS_CFG_RATE_LO     0
`define GCS_CTRL_CONT_BIT   0
`define GCS_CTRL_ABORT_BIT  1
`define GCS_ST_BUSY_BIT     0
`define GCS_ST_POL_BIT      1
`define GCS_ST_READY_BIT    2
`define GCS_ST_ARMED_BIT    3

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define GCS_CFG_RST         8'h14
`define GCS_CTRL_RST        8'h00
`define GCS_DELAY_RST       8'h0E

// ------------------------------------------------------------
// Timing: master clocks per modulator period
// ------------------------------------------------------------
`define GCS_MCLK_PER_MOD    16
`define GCS_MOD_LAST        4'hF
`define GCS_SINC3_HIDDEN    2'h2
`define GCS_RATE_LAST       4'hD

// ------------------------------------------------------------
// First chopped data period, modulator periods, rate codes 0..13
// ------------------------------------------------------------
`define GCS_LL_P0   20'd208130
`define GCS_LL_P1   20'd105730
`define GCS_LL_P2   20'd54530
`define GCS_LL_P3   20'd30850
`define GCS_LL_P4   20'd28930
`define GCS_LL_P5   20'd10320
`define GCS_LL_P6   20'd8658
`define GCS_LL_P7   20'd5200
`define GCS_LL_P8   20'd2640
`define GCS_LL_P9   20'd1360
`define GCS_LL_P10  20'd720
`define GCS_LL_P11  20'd592
`define GCS_LL_P12  20'd336
`define GCS_LL_P13  20'd208
`define GCS_S3_P0   20'd614530
`define GCS_S3_P1   20'd307330
`define GCS_S3_P2   20'd153730
`define GCS_S3_P3   20'd92290
`define GCS_S3_P4   20'd76930
`define GCS_S3_P5   20'd30850
`define GCS_S3_P6   20'd25714
`define GCS_S3_P7   20'd15490
`define GCS_S3_P8   20'd7810
`define GCS_S3_P9   20'd3970
`define GCS_S3_P10  20'd2050
`define GCS_S3_P11  20'd1616
`define GCS_S3_P12  20'd848
`define GCS_S3_P13  20'd464

`endif

// [rtl/gcs_period_timer.v]
// Modulator period timer clocked off master clock ticks
`timescale 1ns/1ps
`include "gcs_defines.vh"

module gcs_period_timer
#(
    parameter CNT_W = 20
)
(
    // Clock and reset
    input  wire             core_clk,
    input  wire             sys_rst,
    // Master clock tick
    input  wire             mclkTick,
    // Control
    input  wire             load,
    input  wire [CNT_W-1:0] loadCount,
    // Status
    output reg              done_r,
    output wire             busy
);

reg  [3:0]       prescale_r;
reg  [CNT_W-1:0] remain_r;
wire             modTick;

// Prescaler restarts on load so a period is always whole modulator periods
assign modTick = mclkTick && (prescale_r == `GCS_MOD_LAST);
assign busy    = (remain_r != {CNT_W{1'b0}});

always @(posedge core_clk)
begin
    if (sys_rst)
    begin
        prescale_r <= 4'h0;
        remain_r   <= {CNT_W{1'b0}};
        done_r     <= 1'b0;
    end
    else
    begin
        done_r <= 1'b0;
        if (load)
        begin
            prescale_r <= 4'h0;
            remain_r   <= loadCount;
        end
        else if (busy)
        begin
            if (mclkTick)
                prescale_r <= prescale_r + 4'h1;
            if (modTick)
            begin
                remain_r <= remain_r - {{(CNT_W-1){1'b0}}, 1'b1};
                if (remain_r == {{(CNT_W-1){1'b0}}, 1'b1})
                    done_r <= 1'b1;
            end
        end
    end
end

endmodule

// [rtl/gcs_chop_average.v]
// Pairs opposite-polarity conversions and averages them to cancel offset
`timescale 1ns/1ps

module gcs_chop_average
#(
    parameter DATA_W = 16
)
(
    // Clock and reset
    input  wire              core_clk,
    input  wire              sys_rst,
    // Incoming conversion
    input  wire [DATA_W-1:0] sample,
    input  wire              sampleStb,
    input  wire              reversed,
    // Averaged result
    output reg  [DATA_W-1:0] avg_r,
    output reg               avgStb_r
);

reg  [DATA_W-1:0] normal_r;
reg  [DATA_W-1:0] rev_r;
reg  [DATA_W:0]   diff;

// Reversed reading is -V+Vos, normal is V+Vos: half the difference is V
always @*
begin
    if (reversed)
        diff = {normal_r[DATA_W-1], normal_r} - {sample[DATA_W-1], sample};
    else
        diff = {sample[DATA_W-1], sample} - {rev_r[DATA_W-1], rev_r};
end

always @(posedge core_clk)
begin
    if (sys_rst)
    begin
        normal_r <= {DATA_W{1'b0}};
        rev_r    <= {DATA_W{1'b0}};
        avg_r    <= {DATA_W{1'b0}};
        avgStb_r <= 1'b0;
    end
    else
    begin
        avgStb_r <= sampleStb;
        if (sampleStb)
        begin
            avg_r <= diff[DATA_W:1];
            if (reversed)
                rev_r <= sample;
            else
                normal_r <= sample;
        end
    end
end

endmodule

// [tb/gcs_seq_props.sv]
// Port-level concurrent checks for the chop sequencer
`timescale 1ns/1ps
`include "gcs_defines.vh"
module gcs_seq_props
#(
    parameter DATA_W = 16
)
(
    // Clock, reset and register writes
    input wire              core_clk,
    input wire              sys_rst,
    input wire [7:0]        regAddr,
    input wire [7:0]        regWrData,
    input wire              regWrStb,
    // Start sources
    input wire              startPin,
    input wire              startCmd,
    // Outputs watched
    input wire              convActive,
    input wire              inputReversed_r,
    input wire [3:0]        filterRate,
    input wire              lowLatencySel,
    input wire [DATA_W-1:0] resultData_r,
    input wire              resultValid_r,
    input wire              dataReady_r
);
    // ----------------------------------------
    // Chop setting as software last wrote it
    // ----------------------------------------
    reg chopOn_r;
    always @(posedge core_clk)
        if (sys_rst)
            chopOn_r <= 1'h0;
        else if (regWrStb && regAddr == `GCS_OFS_RATE_CFG)
            chopOn_r <= regWrData[`GCS_CFG_CHOP_BIT];

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence s_start;
        $rose(startPin) || startCmd;
    endsequence
    sequence s_cfgWr;
        regWrStb && regAddr == `GCS_OFS_RATE_CFG;
    endsequence
    sequence s_plainRun;
        !chopOn_r throughout convActive[*2];
    endsequence

    AST_START_RUNS:
        assert property (s_start |=> convActive) else $error("start not taken");
    AST_CFG_FIELDS:
        assert property (s_cfgWr |=> filterRate == $past(regWrData[3:0])
            && lowLatencySel == $past(regWrData[4])) else $error("config fields wrong");
    AST_VALID_PULSE:
        assert property (resultValid_r |=> !resultValid_r) else $error("valid too long");
    AST_READY_SET:
        assert property (resultValid_r |-> dataReady_r) else $error("ready not set");
    AST_RESULT_HELD:
        assert property (!resultValid_r |-> $stable(resultData_r)) else $error("result moved");
    AST_SWAP_SPACED:
        assert property ($changed(inputReversed_r) && convActive
            |=> $stable(inputReversed_r)[*8]) else $error("swap too soon");
    AST_VALID_FROM_CONV:
        assert property (resultValid_r |-> $past(convActive, 4)) else $error("stray result");
    AST_PLAIN_NO_SWAP:
        assert property (s_plainRun |-> !inputReversed_r) else $error("swap with chop off");
endmodule

bind gcs_chop_sequencer gcs_seq_props #(.DATA_W(DATA_W)) u_props
(
    .core_clk, .sys_rst, .regAddr, .regWrData, .regWrStb, .startPin, .startCmd,
    .convActive, .inputReversed_r, .filterRate, .lowLatencySel, .resultData_r,
    .resultValid_r, .dataReady_r
);

// [tb/gcs_host_model.sv]
// Host model that starts conversions by pin edge or decoded command
`timescale 1ns/1ps
module gcs_host_model
(
    // Clock
    input  wire core_clk,
    // Request from the bench
    input  wire go,
    input  wire useCmd,
    // Start sources toward the block
    output reg  startPin = 1'h0,
    output reg  startCmd = 1'h0
);
    // Pin high for one cycle: only its rising edge starts anything
    always @(posedge core_clk)
    begin
        startPin <= go && !useCmd;
        startCmd <= go && useCmd;
    end
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the chop sequencer
`timescale 1ns/1ps
`include "gcs_defines.vh"
module tb_top;
    localparam LL = 1664;
    localparam S3 = 3712;
    localparam DLY = 16;
    localparam [15:0] POS = 16'h1234;
    localparam [15:0] NEG = 16'hF000;
    localparam [15:0] AVG = 16'h111A;
    reg core_clk = 1'h0;
    reg sys_rst = 1'h1;
    reg [7:0] regAddr = 8'h00;
    reg [7:0] regWrData = 8'h00;
    reg regWrStb = 1'h0;
    reg regRdStb = 1'h0;
    reg mclkTick = 1'h1;
    reg [15:0] filterData = 16'h0000;
    reg go = 1'h0;
    reg useCmd = 1'h0;
    reg pol;
    reg [15:0] rdv;
    wire startPin, startCmd, inputReversed_r, convActive, lowLatencySel;
    wire resultValid_r, dataReady_r;
    wire [3:0] filterRate;
    wire [15:0] regRdData_r, resultData_r;
    integer errors = 0;
    integer n_checks = 0;
    integer n;

    gcs_chop_sequencer u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
        .regRdData_r(regRdData_r), .startPin(startPin), .startCmd(startCmd),
        .mclkTick(mclkTick), .filterData(filterData), .inputReversed_r(inputReversed_r),
        .convActive(convActive), .filterRate(filterRate), .lowLatencySel(lowLatencySel),
        .resultData_r(resultData_r), .resultValid_r(resultValid_r),
        .dataReady_r(dataReady_r));
    gcs_host_model u_host (.core_clk(core_clk), .go(go), .useCmd(useCmd),
        .startPin(startPin), .startCmd(startCmd));

    // Front end: the reversed polarity sees the other reading
    always @(posedge core_clk)
        filterData <= inputReversed_r ? NEG : POS;

    initial
        forever #2.5 core_clk = ~core_clk;

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task chk(input [15:0] seen, input [15:0] exp, input string what);
        n_checks = n_checks + 1;
        if (seen !== exp)
        begin
            errors = errors + 1;
            $display("CHECK FAILED %0s expected %h seen %h", what, exp, seen);
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        @(posedge core_clk);
        regWrStb <= 1'h1;
        regAddr <= a;
        regWrData <= d;
        @(posedge core_clk);
        regWrStb <= 1'h0;
    endtask
    task rd(input [7:0] a);
        @(posedge core_clk);
        regRdStb <= 1'h1;
        regAddr <= a;
        @(posedge core_clk);
        regRdStb <= 1'h0;
        #1 rdv = regRdData_r;
    endtask
    task startSeq(input cmd);
        @(posedge core_clk);
        go <= 1'h1;
        useCmd <= cmd;
        @(posedge core_clk);
        go <= 1'h0;
        @(posedge core_clk);
    endtask
    // Counts edges up to the next result; the bound keeps a hang short
    task waitRes(input integer lo, input integer hi, input string what);
        n = 0;
        do
        begin
            @(posedge core_clk);
            #1 n = n + 1;
        end while (resultValid_r !== 1'h1 && n <= hi);
        chk(16'(n >= lo && n <= hi), 16'h0001, what);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_regs;
        chk({11'h000, lowLatencySel, filterRate}, 16'h0014, "cfg pins");
        rd(`GCS_OFS_RATE_CFG);
        chk(rdv, 16'h0014, "cfg reset");
        rd(`GCS_OFS_DELAY);
        chk(rdv, 16'h000E, "delay reset");
        rd(8'h08);
        chk(rdv, 16'h0000, "unmapped read");
    endtask
    task t_chop_single;
        wr(`GCS_OFS_RATE_CFG, 8'h3D);
        startSeq(1'h0);
        waitRes(2 * (224 + LL), 2 * (224 + LL) + 16, "default delay twice");
        chk(resultData_r, AVG, "chop mean");
        chk(dataReady_r, 1'h1, "ready set");
        rd(`GCS_OFS_RESULT);
        chk(rdv, AVG, "result reg");
        chk(dataReady_r, 1'h0, "ready cleared");
        repeat (8) @(posedge core_clk);
        #1 chk(convActive, 1'h0, "single shot ends");
    endtask
    task t_chop_cont;
        wr(`GCS_OFS_DELAY, 8'h01);
        wr(`GCS_OFS_CTRL, 8'h01);
        startSeq(1'h1);
        waitRes(2 * (DLY + LL), 2 * (DLY + LL) + 16, "chop first");
        pol = inputReversed_r;
        // The timer reload costs one core clock per conversion
        repeat (2)
        begin
            waitRes(LL + 1, LL + 1, "chop period");
            chk(inputReversed_r, !pol, "polarity swap");
            chk(resultData_r, AVG, "pipelined mean");
            pol = inputReversed_r;
        end
        wr(`GCS_OFS_CTRL, 8'h02);
        #1 chk(convActive, 1'h0, "abort");
    endtask
    task t_sinc3_chop;
        wr(`GCS_OFS_RATE_CFG, 8'h2D);
        wr(`GCS_OFS_CTRL, 8'h00);
        startSeq(1'h0);
        waitRes(2 * (DLY + S3), 2 * (DLY + S3) + 16, "sinc3 chop first");
        chk(resultData_r, AVG, "sinc3 mean");
    endtask
    task t_plain;
        wr(`GCS_OFS_RATE_CFG, 8'h0D);
        wr(`GCS_OFS_CTRL, 8'h01);
        startSeq(1'h1);
        waitRes(DLY + 3 * S3, DLY + 3 * S3 + 16, "two hidden");
        chk(resultData_r, POS, "raw result");
        chk(inputReversed_r, 1'h0, "no swap");
        waitRes(S3 + 1, S3 + 1, "plain period");
        wr(`GCS_OFS_CTRL, 8'h02);
    endtask

    task final_report;
        if (errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'h0;
        t_regs;
        t_chop_single;
        t_chop_cont;
        t_sinc3_chop;
        t_plain;
        final_report;
    end
    initial
    begin
        repeat (50000) @(posedge core_clk);
        errors = errors + 1;
        final_report;
    end
endmodule
